// [design/rst_seq_pkg.sv]
// constants, register map and carrier types for the reset time-out sequencer
// assumes a single 50 MHz clock; slower time bases come from enable pulses
package rst_seq_pkg;

	localparam int CLK_HZ = 50000000;
	localparam int POWERUP_DELAY_MS = 64;
	localparam int POWERUP_DELAY_CYC = POWERUP_DELAY_MS * (CLK_HZ / 1000);
	localparam int LFOSC_HZ = 15000;
	localparam int LFOSC_DIV = CLK_HZ / LFOSC_HZ;
	localparam int LF_TICKS = (POWERUP_DELAY_MS * LFOSC_HZ) / 1000;
	localparam logic [10:0] OSC_STARTUP_PERIODS = 11'h400;

	// register indices on the plain port
	localparam logic [7:0] ADDR_CORE_STATUS = 8'h03;
	localparam logic [7:0] ADDR_POWER_CONTROL = 8'h8e;
	localparam logic [7:0] ADDR_IRQ_STATUS = 8'hf0;
	localparam logic [7:0] ADDR_IRQ_MASK = 8'hf1;
	localparam logic [7:0] ADDR_CAUSE = 8'hf2;

	// power control fields
	localparam int PCTL_BROWNOUT_BIT = 0;
	localparam int PCTL_POWERON_BIT = 1;
	// core status fields
	localparam int STAT_POWERDOWN_BIT = 3;
	localparam int STAT_TIMEOUT_BIT = 4;

	localparam logic [7:0] STATUS_POR_VALUE = 8'h18;
	localparam logic [7:0] PROG_COUNTER_LOW_RESET = 8'h00;
	localparam logic [7:0] IRQ_MASK_RESET = 8'h00;

	// interrupt status bits: 0 released, 1 brown-out, 2 watchdog, 3 wake-up
	localparam int IRQ_RUN = 0;
	localparam int IRQ_BROWNOUT = 1;
	localparam int IRQ_WATCHDOG = 2;
	localparam int IRQ_WAKE = 3;

	typedef enum logic [2:0] {
		OSC_LOW_CRYSTAL, OSC_CRYSTAL, OSC_FAST_CRYSTAL, OSC_RC, OSC_EXT_CLOCK, OSC_INTERNAL
	} osc_mode_t;

	typedef struct packed {
		logic power_on;
		logic brownout;
		logic watchdog;
		logic wake;
		logic ext_pin;
	} cause_t;

	typedef struct packed {
		logic [7:0] addr;
		logic [7:0] wdata;
		logic wr;
		logic rd;
	} bus_req_t;

endpackage

// [design/tick_divider.sv]
// one-cycle enable pulse every DIV clocks
// assumes synchronous active-low reset copy from the top
`timescale 1ns/1ns
module tick_divider import rst_seq_pkg::*; #(
	parameter int DIV = 4
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// pulse
	output logic tick
);
	logic [15:0] cnt;
	logic [15:0] next_cnt;
	logic next_tick;

	always_comb begin
		next_tick = 1'b0;
		next_cnt = cnt + 16'h0001;
		if (cnt == 16'(DIV - 1)) begin
			next_cnt = 16'h0000;
			next_tick = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= 16'h0000;
			tick <= 1'b0;
		end else begin
			cnt <= next_cnt;
			tick <= next_tick;
		end
	end
endmodule

// [design/stage_counter.sv]
// restartable down-counter paced by an enable pulse
// done is high once the load value has been counted out
`timescale 1ns/1ns
module stage_counter import rst_seq_pkg::*; #(
	parameter int W = 11
) (
	// clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// control
	input wire logic restart,
	input wire logic run,
	input wire logic step,
	input wire logic [W-1:0] load,
	// status
	output logic done
);
	logic [W-1:0] cnt;
	logic [W-1:0] next_cnt;
	logic next_done;

	always_comb begin
		next_cnt = cnt;
		next_done = done;
		if (restart) begin
			next_cnt = load;
			next_done = 1'b0;
		end else if (run && step && !done) begin
			next_cnt = cnt - {{(W-1){1'b0}}, 1'b1};
			if (cnt <= {{(W-1){1'b0}}, 1'b1})
				next_done = 1'b1;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			cnt <= '0;
			done <= 1'b0;
		end else begin
			cnt <= next_cnt;
			done <= next_done;
		end
	end
endmodule

// [design/reset_timeout_sequencer.sv]
// reset time-out sequencer: power-up delay, oscillator start-up, cause flags
// assumes supply monitor, pin and core events are synchronous to CLOCK
//
// Implementation choice: the address-and-strobe port.
`timescale 1ns/1ns
module reset_timeout_sequencer import rst_seq_pkg::*; (
	// clock and reset
	input wire logic CLOCK,
	input wire logic NRST,
	// supply monitors and pin
	input wire logic POR_PULSE,
	input wire logic BROWNOUT,
	input wire logic EXT_RESET_PIN_N,
	// core events
	input wire logic WATCHDOG_RESET,
	input wire logic WATCHDOG_WAKE,
	input wire logic IRQ_WAKE_EV,
	input wire logic SLEEPING,
	input wire logic MAIN_OSC_TICK,
	// configuration
	input wire logic POWERUP_TIMER_DISABLE,
	input wire logic [1:0] BROWNOUT_ENABLE_SEL,
	input wire logic [2:0] OSC_MODE,
	input wire logic SECONDARY_OSC_ON,
	input wire logic [7:0] PC_LOW,
	// register port
	input wire logic [7:0] ADDR,
	input wire logic [7:0] WDATA,
	input wire logic WR,
	input wire logic RD,
	output logic [7:0] RDATA,
	// core control
	output logic CORE_RESET,
	output logic [7:0] PROG_COUNTER_LOW,
	output logic IRQ
);
	// ------------------------------------------------------------
	// reset release
	// ------------------------------------------------------------
	logic rst_meta, rst_n;
	always_ff @(posedge CLOCK or negedge NRST) begin
		if (!NRST) begin
			rst_meta <= 1'b0;
			rst_n <= 1'b0;
		end else begin
			rst_meta <= 1'b1;
			rst_n <= rst_meta;
		end
	end

	// ------------------------------------------------------------
	// sequencer
	// ------------------------------------------------------------
	typedef enum logic [2:0] {ST_POR, ST_DELAY, ST_STARTUP, ST_HOLD, ST_RUN} seq_state_t;
	seq_state_t state, next_state;
	bus_req_t req;
	osc_mode_t mode;
	logic lf_tick, delay_done, startup_done, delay_restart, startup_restart;
	logic crystal, startup_needed, next_core_reset;

	assign req = '{addr: ADDR, wdata: WDATA, wr: WR, rd: RD};
	assign mode = osc_mode_t'(OSC_MODE);
	assign crystal = (mode == OSC_CRYSTAL) || (mode == OSC_FAST_CRYSTAL)
		|| (mode == OSC_LOW_CRYSTAL);
	// on a wake, low-power crystal counts only with the secondary oscillator off
	assign startup_needed = crystal && !(mode == OSC_LOW_CRYSTAL && SECONDARY_OSC_ON);

	tick_divider #(.DIV(LFOSC_DIV)) u_lf (
		.clk(CLOCK),
		.rst_n(rst_n),
		.tick(lf_tick)
	);

	// power-up delay on the low-frequency tick, start-up on main osc tick
	stage_counter #(.W(11)) u_delay (
		.clk(CLOCK),
		.rst_n(rst_n),
		.restart(delay_restart),
		.run(state == ST_DELAY),
		.step(lf_tick),
		.load(11'(LF_TICKS)),
		.done(delay_done)
	);

	stage_counter #(.W(11)) u_startup (
		.clk(CLOCK),
		.rst_n(rst_n),
		.restart(startup_restart),
		.run(state == ST_STARTUP),
		.step(MAIN_OSC_TICK),
		.load(OSC_STARTUP_PERIODS),
		.done(startup_done)
	);

	// detection off leaves the brown-out flag untouched: don't-care
	logic brownout_active;
	assign brownout_active = BROWNOUT && BROWNOUT_ENABLE_SEL[1]
		&& !(BROWNOUT_ENABLE_SEL == 2'b10 && SLEEPING);

	always_comb begin
		next_state = state;
		delay_restart = 1'b0;
		startup_restart = 1'b0;
		case (state)
			ST_POR: begin
				delay_restart = 1'b1;
				startup_restart = 1'b1;
				if (!POR_PULSE && !brownout_active) begin
					if (!POWERUP_TIMER_DISABLE)
						next_state = ST_DELAY;
					else if (crystal)
						next_state = ST_STARTUP;
					else
						next_state = ST_HOLD;
				end
			end
			ST_DELAY: begin
				if (delay_done)
					next_state = crystal ? ST_STARTUP : ST_HOLD;
			end
			ST_STARTUP: if (startup_done) next_state = ST_HOLD;
			ST_HOLD: if (EXT_RESET_PIN_N) next_state = ST_RUN;
			ST_RUN: begin
				if (!EXT_RESET_PIN_N)
					next_state = ST_HOLD;
				if ((WATCHDOG_WAKE || IRQ_WAKE_EV) && startup_needed) begin
					startup_restart = 1'b1;
					next_state = ST_STARTUP;
				end
			end
			default: next_state = ST_POR;
		endcase
		if (POR_PULSE || brownout_active)
			next_state = ST_POR;
	end
	assign next_core_reset = (next_state != ST_RUN);

	always_ff @(posedge CLOCK or negedge rst_n) begin
		if (!rst_n) begin
			state <= ST_POR;
			CORE_RESET <= 1'b1;
		end else begin
			state <= next_state;
			CORE_RESET <= next_core_reset;
		end
	end

	// ------------------------------------------------------------
	// cause flags and registers
	// ------------------------------------------------------------
	logic [7:0] power_control, core_status, irq_status, irq_mask;
	logic [7:0] next_power_control, next_core_status, next_irq_status, next_irq_mask;
	logic [7:0] next_prog_counter_low, next_rdata;
	cause_t cause, next_cause;
	logic ext_reset_ev, running_ev, next_irq;
	logic pin_q;

	assign ext_reset_ev = pin_q && !EXT_RESET_PIN_N;
	assign running_ev = (state != ST_RUN) && (next_state == ST_RUN);

	always_comb begin
		next_power_control = power_control;
		next_core_status = core_status;
		next_prog_counter_low = PROG_COUNTER_LOW;
		next_cause = '0;
		next_irq_mask = irq_mask;
		next_irq_status = irq_status;
		if (req.wr && req.addr == ADDR_POWER_CONTROL)
			next_power_control = req.wdata & 8'h03;
		if (req.wr && req.addr == ADDR_CORE_STATUS)
			next_core_status = {core_status[7:5],
				core_status[STAT_TIMEOUT_BIT:STAT_POWERDOWN_BIT], req.wdata[2:0]};
		if (req.wr && req.addr == ADDR_IRQ_MASK)
			next_irq_mask = req.wdata & 8'h0f;
		if (req.wr && req.addr == ADDR_IRQ_STATUS)
			next_irq_status = irq_status & ~req.wdata;
		if (POR_PULSE) begin
			next_cause.power_on = 1'b1;
			next_power_control[PCTL_POWERON_BIT] = 1'b0;
			next_core_status = STATUS_POR_VALUE;
			next_prog_counter_low = PROG_COUNTER_LOW_RESET;
		end else if (brownout_active) begin
			next_cause.brownout = 1'b1;
			next_power_control[PCTL_BROWNOUT_BIT] = 1'b0;
			next_core_status = {3'b000, 2'b11, core_status[2:0]};
			next_prog_counter_low = PROG_COUNTER_LOW_RESET;
		end else if (WATCHDOG_RESET) begin
			next_cause.watchdog = 1'b1;
			next_core_status = {3'b000, 1'b0, 1'b1, core_status[2:0]};
			next_prog_counter_low = PROG_COUNTER_LOW_RESET;
		end else if (WATCHDOG_WAKE) begin
			next_cause.wake = 1'b1;
			next_core_status[STAT_TIMEOUT_BIT] = 1'b0;
			next_core_status[STAT_POWERDOWN_BIT] = 1'b0;
			next_prog_counter_low = PC_LOW + 8'h01;
		end else if (ext_reset_ev) begin
			next_cause.ext_pin = 1'b1;
			next_core_status[7:5] = 3'b000;
			if (SLEEPING) begin
				next_core_status[STAT_TIMEOUT_BIT] = 1'b1;
				next_core_status[STAT_POWERDOWN_BIT] = 1'b0;
			end
			next_prog_counter_low = PROG_COUNTER_LOW_RESET;
		end else if (IRQ_WAKE_EV) begin
			next_cause.wake = 1'b1;
			next_core_status[STAT_TIMEOUT_BIT] = 1'b1;
			next_core_status[STAT_POWERDOWN_BIT] = 1'b0;
			next_prog_counter_low = PC_LOW + 8'h01;
		end
		// hardware set wins over a software clear in the same cycle
		next_irq_status[IRQ_RUN] = next_irq_status[IRQ_RUN] | running_ev;
		next_irq_status[IRQ_BROWNOUT] = next_irq_status[IRQ_BROWNOUT] | next_cause.brownout;
		next_irq_status[IRQ_WATCHDOG] = next_irq_status[IRQ_WATCHDOG] | next_cause.watchdog;
		next_irq_status[IRQ_WAKE] = next_irq_status[IRQ_WAKE] | next_cause.wake;
		next_irq = |(next_irq_status & irq_mask);
		case (req.addr)
			ADDR_POWER_CONTROL: next_rdata = power_control;
			ADDR_CORE_STATUS: next_rdata = core_status;
			ADDR_IRQ_STATUS: next_rdata = irq_status;
			ADDR_IRQ_MASK: next_rdata = irq_mask;
			ADDR_CAUSE: next_rdata = {3'b000, cause};
			default: next_rdata = 8'h00;
		endcase
		if (!req.rd)
			next_rdata = 8'h00;
	end

	always_ff @(posedge CLOCK or negedge rst_n) begin
		if (!rst_n) begin
			power_control <= 8'h00;
			core_status <= STATUS_POR_VALUE;
			irq_status <= 8'h00;
			irq_mask <= IRQ_MASK_RESET;
			cause <= '0;
			pin_q <= 1'b1;
			PROG_COUNTER_LOW <= PROG_COUNTER_LOW_RESET;
			RDATA <= 8'h00;
			IRQ <= 1'b0;
		end else begin
			power_control <= next_power_control;
			core_status <= next_core_status;
			irq_status <= next_irq_status;
			irq_mask <= next_irq_mask;
			if (next_cause != '0)
				cause <= next_cause;
			pin_q <= EXT_RESET_PIN_N;
			PROG_COUNTER_LOW <= next_prog_counter_low;
			RDATA <= next_rdata;
			IRQ <= next_irq;
		end
	end

	// ------------------------------------------------------------
	// checks
	// ------------------------------------------------------------
	AST_POR_HOLDS: assert property (@(posedge CLOCK) disable iff (!rst_n)
		POR_PULSE |=> state == ST_POR) else $error("power-on pulse did not hold sequencer");
	AST_DELAY_FIRST: assert property (@(posedge CLOCK) disable iff (!rst_n)
		(state == ST_POR && next_state != ST_POR && !POWERUP_TIMER_DISABLE)
		|=> state == ST_DELAY) else $error("power-up delay skipped");
	AST_NO_DELAY: assert property (@(posedge CLOCK) disable iff (!rst_n)
		(state == ST_POR && !POR_PULSE && !brownout_active && POWERUP_TIMER_DISABLE
		&& !crystal) |=> state == ST_HOLD) else $error("disabled timer still delayed");
	AST_PIN_RELEASE: assert property (@(posedge CLOCK) disable iff (!rst_n)
		(state == ST_HOLD && EXT_RESET_PIN_N && !POR_PULSE && !brownout_active)
		|=> !CORE_RESET) else $error("pin release did not start at once");
	AST_CRYSTAL_STARTUP: assert property (@(posedge CLOCK) disable iff (!rst_n)
		(state == ST_DELAY && delay_done && crystal && !POR_PULSE && !brownout_active)
		|=> state == ST_STARTUP) else $error("start-up count skipped");
	AST_WAKE_STARTUP: assert property (@(posedge CLOCK) disable iff (!rst_n)
		(state == ST_RUN && (WATCHDOG_WAKE || IRQ_WAKE_EV) && startup_needed
		&& !POR_PULSE && !brownout_active) |=> state == ST_STARTUP && CORE_RESET)
		else $error("wake skipped start-up count");
	AST_BROWNOUT_FLAG: assert property (@(posedge CLOCK) disable iff (!rst_n)
		(brownout_active && !POR_PULSE) |=> !power_control[PCTL_BROWNOUT_BIT])
		else $error("brown-out flag not cleared");
	AST_POR_FLAG: assert property (@(posedge CLOCK) disable iff (!rst_n)
		POR_PULSE |=> !power_control[PCTL_POWERON_BIT] && core_status == STATUS_POR_VALUE)
		else $error("power-on flags wrong");
	AST_WATCHDOG_WAKE: assert property (@(posedge CLOCK) disable iff (!rst_n)
		(WATCHDOG_WAKE && !POR_PULSE && !brownout_active && !WATCHDOG_RESET)
		|=> !core_status[STAT_TIMEOUT_BIT] && !core_status[STAT_POWERDOWN_BIT]
		&& PROG_COUNTER_LOW == $past(PC_LOW) + 8'h01) else $error("watchdog wake encoding wrong");
	AST_BROWNOUT_RESTART: assert property (@(posedge CLOCK) disable iff (!rst_n)
		(state == ST_DELAY && brownout_active) |=> state == ST_POR ##1 !delay_done)
		else $error("brown-out did not restart delay");
	AST_PIN_SLEEP: assert property (@(posedge CLOCK) disable iff (!rst_n)
		(ext_reset_ev && SLEEPING && !POR_PULSE && !brownout_active && !WATCHDOG_RESET
		&& !WATCHDOG_WAKE)
		|=> core_status[STAT_TIMEOUT_BIT] && !core_status[STAT_POWERDOWN_BIT])
		else $error("pin reset in sleep flags wrong");
endmodule

// [test/osc_core_model.sv]
// main oscillator model: one tick per period, fast or at half rate
// assumes the bench clock; ticks change just after the rising edge
`timescale 1ns/1ns
module osc_core_model (
	// clock and rate
	input wire logic clk,
	input wire logic slow,
	// oscillator period pulse
	output logic tick
);
	logic phase;

	initial begin
		phase = 1'b0;
		tick = 1'b0;
	end

	// half rate exercises a start-up count that is not one tick a clock
	always @(posedge clk) begin
		phase <= ~phase;
		tick <= ~slow | phase;
	end
endmodule

// [test/test_reset_timeout_sequencer.sv]
// self-checking bench for the reset time-out sequencer
// assumes the package constants; the 64 ms delay is kept disabled throughout
`timescale 1ns/1ns
module test_reset_timeout_sequencer import rst_seq_pkg::*;;
	logic clock = 1'b0, nrst = 1'b0, por = 1'b0, bo = 1'b0, pin_n = 1'b1;
	logic wdr = 1'b0, wdw = 1'b0, irqw = 1'b0, sleeping = 1'b0, slow = 1'b0;
	logic ptd = 1'b1, sec = 1'b0, wr = 1'b0, rd = 1'b0, core_reset, irq, tick;
	logic [1:0] bsel = 2'b11;
	logic [2:0] osc = 3'h4;
	logic [7:0] pc = 8'h00, addr = 8'h00, wdata = 8'h00, rdata, pc_load, v;
	integer err_count = 0, tests_run = 0, seed = 95, osc_seen = 0, k;

	osc_core_model MODEL (.clk(clock), .slow(slow), .tick(tick));

	reset_timeout_sequencer DUT (.CLOCK(clock), .NRST(nrst), .POR_PULSE(por),
		.BROWNOUT(bo), .EXT_RESET_PIN_N(pin_n), .WATCHDOG_RESET(wdr),
		.WATCHDOG_WAKE(wdw), .IRQ_WAKE_EV(irqw), .SLEEPING(sleeping),
		.MAIN_OSC_TICK(tick), .POWERUP_TIMER_DISABLE(ptd), .BROWNOUT_ENABLE_SEL(bsel),
		.OSC_MODE(osc), .SECONDARY_OSC_ON(sec), .PC_LOW(pc), .ADDR(addr),
		.WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .CORE_RESET(core_reset),
		.PROG_COUNTER_LOW(pc_load), .IRQ(irq));

	initial begin
		forever #10 clock = ~clock;
	end

	always @(posedge clock) begin
		if (tick === 1'b1) begin
			osc_seen = osc_seen + 1;
		end
	end

	// ----------------------------------------
	// tasks
	// ----------------------------------------
	task automatic end_of_test;
		$display("comparisons %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input logic [7:0] m);
		tests_run = tests_run + 1;
		if ((got & m) !== (exp & m)) begin
			err_count = err_count + 1;
			$display("Error at %0t: got %h expected %h", $time, got & m, exp & m);
		end
	endtask

	task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
		@(posedge clock);
		addr <= a;
		wdata <= d;
		wr <= 1'b1;
		@(posedge clock);
		wr <= 1'b0;
	endtask

	task automatic rd_reg(input logic [7:0] a, output logic [7:0] d);
		@(posedge clock);
		addr <= a;
		rd <= 1'b1;
		@(posedge clock);
		rd <= 1'b0;
		#1 d = rdata;
	endtask

	// one-cycle core events: {watchdog reset, watchdog wake, interrupt wake}
	task automatic fire(input logic [2:0] e);
		@(posedge clock);
		{wdr, wdw, irqw} <= e;
		@(posedge clock);
		{wdr, wdw, irqw} <= 3'h0;
		repeat (4) @(posedge clock);
	endtask

	task automatic power_up(input logic [2:0] m);
		@(posedge clock);
		osc <= m;
		por <= 1'b1;
		repeat (3) @(posedge clock);
		por <= 1'b0;
		osc_seen = 0;
	endtask

	// bounded wait for the core to leave reset, then check it did
	task automatic wait_run(input int lim);
		int n;
		n = 0;
		while (core_reset !== 1'b0 && n < lim) begin
			@(posedge clock);
			#1;
			n = n + 1;
		end
		chk8({7'h00, core_reset}, 8'h00, 8'h01);
	endtask

	initial begin
		#1000000;
		err_count = err_count + 1;
		end_of_test();
	end

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		repeat (4) @(posedge clock);
		nrst <= 1'b1;
		repeat (4) @(posedge clock);
		for (k = 3; k <= 5; k++) begin
			power_up(k[2:0]);
			wait_run(8);
			chk8(pc_load, PROG_COUNTER_LOW_RESET, 8'hff);
		end
		rd_reg(ADDR_CORE_STATUS, v);
		chk8(v, STATUS_POR_VALUE, 8'hf8);
		rd_reg(ADDR_POWER_CONTROL, v);
		chk8(v, 8'h00, 8'h02);
		wr_reg(ADDR_POWER_CONTROL, 8'h03);
		rd_reg(ADDR_POWER_CONTROL, v);
		chk8(v, 8'h03, 8'h03);
		rd_reg(8'h55, v);
		chk8(v, 8'h00, 8'hff);
		$display("test power-on done");

		wr_reg(ADDR_IRQ_STATUS, 8'hff);
		fire(3'h4);
		rd_reg(ADDR_CORE_STATUS, v);
		chk8(v, 8'h00, 8'h10);
		rd_reg(ADDR_POWER_CONTROL, v);
		chk8(v, 8'h03, 8'h03);
		rd_reg(ADDR_CAUSE, v);
		chk8(v, 8'h04, 8'h1f);
		wr_reg(ADDR_IRQ_MASK, 8'h00);
		repeat (3) @(posedge clock);
		#1 chk8({7'h00, irq}, 8'h00, 8'h01);
		v = (8'($random(seed)) & 8'hf4) | 8'h04;
		wr_reg(ADDR_IRQ_MASK, v);
		repeat (3) @(posedge clock);
		#1 chk8({7'h00, irq}, 8'h01, 8'h01);
		wr_reg(ADDR_IRQ_STATUS, 8'h04);
		repeat (3) @(posedge clock);
		#1 chk8({7'h00, irq}, 8'h00, 8'h01);
		$display("test watchdog done");

		@(posedge clock);
		bo <= 1'b1;
		repeat (5) @(posedge clock);
		bo <= 1'b0;
		wait_run(8);
		rd_reg(ADDR_CORE_STATUS, v);
		chk8(v, 8'h18, 8'h18);
		rd_reg(ADDR_POWER_CONTROL, v);
		chk8(v, 8'h02, 8'h03);
		wr_reg(ADDR_POWER_CONTROL, 8'h03);
		bsel <= 2'b00;
		bo <= 1'b1;
		repeat (3) @(posedge clock);
		#1 chk8({7'h00, core_reset}, 8'h00, 8'h01);
		bo <= 1'b0;
		bsel <= 2'b11;
		rd_reg(ADDR_POWER_CONTROL, v);
		chk8(v, 8'h03, 8'h03);
		$display("test brown-out done");

		for (k = 1; k <= 2; k++) begin
			@(posedge clock);
			sleeping <= 1'b1;
			pc <= 8'($random(seed));
			fire(k[2:0]);
			sleeping <= 1'b0;
			wait_run(4);
			chk8(pc_load, pc + 8'h01, 8'hff);
		end
		rd_reg(ADDR_CAUSE, v);
		chk8(v, 8'h02, 8'h02);
		@(posedge clock);
		sleeping <= 1'b1;
		pin_n <= 1'b0;
		repeat (5) @(posedge clock);
		pin_n <= 1'b1;
		@(posedge clock);
		sleeping <= 1'b0;
		wait_run(8);
		rd_reg(ADDR_CORE_STATUS, v);
		chk8(v, 8'h10, 8'h18);
		@(posedge clock);
		pin_n <= 1'b0;
		repeat (5) @(posedge clock);
		pin_n <= 1'b1;
		wait_run(8);
		rd_reg(ADDR_CORE_STATUS, v);
		chk8(v, 8'h10, 8'h18);
		rd_reg(ADDR_POWER_CONTROL, v);
		chk8(v, 8'h03, 8'h03);
		$display("test sleep and pin done");

		// crystal start-up with the pin held low past the count
		slow <= 1'b1;
		pin_n <= 1'b0;
		power_up(OSC_CRYSTAL);
		wait (osc_seen >= 1000);
		#1 chk8({7'h00, core_reset}, 8'h01, 8'h01);
		wait (osc_seen >= 1030);
		#1 chk8({7'h00, core_reset}, 8'h01, 8'h01);
		@(posedge clock);
		pin_n <= 1'b1;
		wait_run(3);
		for (k = 2; k >= 0; k -= 2) begin
			slow <= 1'($random(seed));
			power_up(k[2:0]);
			wait_run(2100);
			chk8({7'h00, osc_seen >= 1024 && osc_seen <= 1028}, 8'h01, 8'h01);
		end
		// low-power crystal: secondary oscillator on skips the wake count
		sec <= 1'b1;
		sleeping <= 1'b1;
		fire(3'h2);
		#1 chk8({7'h00, core_reset}, 8'h00, 8'h01);
		sec <= 1'b0;
		fire(3'h1);
		sleeping <= 1'b0;
		#1 chk8({7'h00, core_reset}, 8'h01, 8'h01);
		wait_run(2100);
		$display("test crystal start-up done");
		end_of_test();
	end
endmodule
